// *** hw/clrc_device.sv ***
// Controller end: channel 5 latch, stand-by, resets, limp-home, SPI slave.
// Assumes SPI pins and channel pins come from outside the system clock.
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module clrc_device import clrc_pkg::*; (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // SPI link
    clrc_spi_if.dev spi,
    // Channel and mode pins
    input wire logic i_ch5_input_pin,
    input wire logic i_limp_home_input,
    // Power stage and status
    output logic o_ch5_gate,
    output logic o_standby,
    output logic o_thermal_latch_clear,
    output logic o_limp_home_active
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [4:0] raw;
    logic [4:0] s1_q;
    logic [4:0] s2_q;
    logic [4:0] s3_q;
    logic [4:0] f_q;
    logic [4:0] f_d;
    logic [4:0] fp_q;
    assign raw = {i_limp_home_input, i_ch5_input_pin, spi.mosi, spi.cs_n,
                  spi.sclk};
    // Take a change only once the second and third stages agree
    assign f_d = (s2_q & s3_q) | (f_q & (s2_q ^ s3_q));
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            s1_q <= SYNC_RESET;
            s2_q <= SYNC_RESET;
            s3_q <= SYNC_RESET;
            f_q <= SYNC_RESET;
            fp_q <= SYNC_RESET;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            f_q <= f_d;
            fp_q <= f_q;
        end
    end

    wire sclk_rise = f_q[SY_SCLK] & ~fp_q[SY_SCLK];
    wire sclk_fall = ~f_q[SY_SCLK] & fp_q[SY_SCLK];
    wire cs_active = ~f_q[SY_CSN];
    wire cs_fall = ~f_q[SY_CSN] & fp_q[SY_CSN];
    wire cs_rise = f_q[SY_CSN] & ~fp_q[SY_CSN];
    wire pin = f_q[SY_PIN];
    // R13: limp-home entry
    wire limp = f_q[SY_LHI];
    wire limp_rise = f_q[SY_LHI] & ~fp_q[SY_LHI];

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic lch_q;
    logic bit0_q;
    logic req_q;
    logic [2:0] out_hi_q;
    logic [2:0] mux_q;
    logic cmd_rst_q;
    logic latch_q;
    logic ch5_on;
    logic stb_q;
    logic ter_q;
    logic [2:0] last_sel_q;
    logic [7:0] rx_q;
    logic [7:0] tx_q;
    logic [3:0] bits_q;
    logic miso_q;
    logic miso_oe_q;

    function automatic logic [3:0] reg_read(input logic [2:0] sel,
                                            input logic ch5,
                                            input logic crank_latch_enable,
                                            input logic stb,
                                            input logic b0,
                                            input logic [3:0] outr,
                                            input logic [2:0] mux,
                                            input logic lh);
        logic [3:0] r;
        r = 4'h0;
        case (sel)
            // R4: channel state in bit 3; R15: stand-by in bit 1
            SEL_CONFIG: r = {ch5, crank_latch_enable, stb, b0};
            SEL_OUT: r = outr;
            SEL_MUX: r = {1'b0, mux};
            // R12: limp-home status stays readable
            SEL_STATUS: r = {3'h0, lh};
            default: r = 4'h0;
        endcase
        return r;
    endfunction : reg_read

    // R14: frame decode
    wire frame_ok = cs_rise && (bits_q == FRAME_LEN);
    wire frame_bad = cs_rise && (bits_q != FRAME_LEN);
    wire [2:0] rx_sel = rx_q[F_SEL_HI:F_SEL_LO];
    wire [3:0] rx_data = rx_q[F_DATA_HI:0];
    // R12: writes are dropped while in limp-home
    wire wr_en = frame_ok && rx_q[F_WRITE] && !limp;
    wire wr_cfg = wr_en && (rx_sel == SEL_CONFIG);
    wire wr_out = wr_en && (rx_sel == SEL_OUT);
    wire wr_mux = wr_en && (rx_sel == SEL_MUX);
    // R6: any reset source clears registers
    // R11: limp-home holds writable registers at reset
    wire reg_rst = i_reset | cmd_rst_q | limp;
    wire rst_evt = i_reset | cmd_rst_q | limp_rise;
    wire [3:0] rd_now = reg_read(last_sel_q, ch5_on, lch_q, stb_q, bit0_q,
                                 {out_hi_q, req_q}, mux_q, limp);
    wire [7:0] resp = {ter_q, last_sel_q, rd_now};

    // ------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (reg_rst) begin
            // R1: latch enabled after every reset
            lch_q <= LCH_RESET;
            bit0_q <= BIT0_RESET;
            req_q <= 1'b0;
            out_hi_q <= OUT_RESET;
            mux_q <= MUX_DEFAULT;
        end else begin
            if (wr_cfg) begin
                // R16: latch enable at bit 2
                lch_q <= rx_data[CFG_LCH];
                // R19: bit 0 stored as written
                bit0_q <= rx_data[CFG_BIT0];
            end
            if (wr_out) begin
                req_q <= rx_data[OUT_CH5];
                out_hi_q <= rx_data[F_DATA_HI:1];
            end
            if (wr_mux) begin
                mux_q <= rx_data[2:0];
            end
        end
    end

    // R9: reset command is a one-cycle pulse
    // R20: bit 3 ignored, command not stored
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            cmd_rst_q <= 1'b0;
        end else begin
            cmd_rst_q <= wr_cfg & rx_data[CFG_STB_RST];
        end
    end

    // ------------------------------------------------------------
    // Channel 5 latch and stand-by
    // ------------------------------------------------------------
    // R11: in limp-home the output follows its pin only
    assign ch5_on = limp ? pin : (latch_q | pin | req_q);
    // Of the resets only system reset and limp-home clear the latch, so a soft reset keeps the load
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            latch_q <= 1'b0;
            stb_q <= 1'b0;
            o_ch5_gate <= 1'b0;
            o_standby <= 1'b0;
            o_thermal_latch_clear <= 1'b0;
            o_limp_home_active <= 1'b0;
        end else begin
            // R18: latch off during limp-home
            if (limp || !lch_q) begin
                latch_q <= 1'b0;
            // R2: set by pin or request bit
            end else if (pin || req_q) begin
                latch_q <= 1'b1;
            end
            // R17: stand-by on default mux with channel off
            // R5: dropped one cycle after channel 5 turns on
            stb_q <= (mux_q == MUX_DEFAULT) && !ch5_on && !limp;
            o_thermal_latch_clear <= (mux_q == MUX_DEFAULT) && !ch5_on &&
                                     !limp && !stb_q;
            o_ch5_gate <= ch5_on;
            o_standby <= stb_q;
            o_limp_home_active <= limp;
        end
    end

    // ------------------------------------------------------------
    // SPI slave
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            rx_q <= 8'h00;
            tx_q <= 8'h00;
            bits_q <= 4'h0;
            miso_q <= 1'b1;
            miso_oe_q <= 1'b0;
        end else begin
            miso_oe_q <= cs_active;
            if (cs_fall) begin
                tx_q <= resp;
                miso_q <= resp[FRAME_BITS - 1];
                bits_q <= 4'h0;
            end else if (cs_active && sclk_rise) begin
                rx_q <= {rx_q[6:0], f_q[SY_MOSI]};
                if (bits_q != 4'hf) begin
                    bits_q <= bits_q + 4'h1;
                end
            end else if (cs_active && sclk_fall) begin
                tx_q <= {tx_q[6:0], 1'b0};
                miso_q <= tx_q[6];
            end
        end
    end

    // R7: after reset answer the output register with error set
    always_ff @(posedge i_sys_clk) begin
        if (rst_evt) begin
            ter_q <= 1'b1;
            last_sel_q <= SEL_OUT;
        end else begin
            // A bad frame on the same cycle wins over the clear
            if (frame_bad) begin
                ter_q <= 1'b1;
            end else if (cs_fall) begin
                ter_q <= 1'b0;
            end
            if (frame_ok) begin
                last_sel_q <= rx_sel;
            end
        end
    end

    assign spi.miso = miso_q;
    assign spi.miso_oe = miso_oe_q;
endmodule : clrc_device
`default_nettype wire

// *** pkg/clrc_pkg.sv ***
// Shared constants for the crank latch and reset controller pair.
// Assumes both ends run on one 125 MHz system clock, SPI mode 0, MSB first.
//
// Behaviour
// R1: Latch enable is one after reset.
// R2: Pin or request bit sets latch.
// R3: Host clears requests before dropping latch.
// R4: Configuration read bit 3 shows channel state.
// R5: No stand-by while channel is on. The code drops o_standby one cycle after o_ch5_gate rises.
// R6: Resets clear registers, not power stage.
// R7: First frame returns output register, error set.
// R8: Host waits wake-up delay after reset.
// R9: Reset command bit resets like power-on.
// R10: Host waits transfer delay after command.
// R11: Limp-home holds registers reset, pins drive.
// R12: Limp-home keeps reads, discards writes.
// R13: Limp-home pin high enters limp-home.
// R14: Frame is flag, bank, address, data.
// R15: Read bit 1 is stand-by flag.
// R16: Configuration bit 2 is latch enable.
// R17: Default mux and channel off enters stand-by.
// R18: Latch disabled during limp-home.
// R19: Configuration bit 0 stored and read back.
// R20: Write bit 3 ignored, reset not stored.
package clrc_pkg;
    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 8;
    localparam int F_WRITE = 7;
    localparam int F_SEL_HI = 6;
    localparam int F_SEL_LO = 4;
    localparam int F_DATA_HI = 3;
    localparam logic [3:0] FRAME_LEN = 4'h8;
    // ------------------------------------------------------------
    // Register selects: {bank, address}
    // ------------------------------------------------------------
    localparam logic [2:0] SEL_OUT = 3'h0;
    localparam logic [2:0] SEL_MUX = 3'h1;
    localparam logic [2:0] SEL_STATUS = 3'h2;
    localparam logic [2:0] SEL_CONFIG = 3'h6;
    // ------------------------------------------------------------
    // Configuration fields and reset values
    // ------------------------------------------------------------
    localparam int CFG_CH5 = 3;
    localparam int CFG_LCH = 2;
    localparam int CFG_STB_RST = 1;
    localparam int CFG_BIT0 = 0;
    localparam int OUT_CH5 = 0;
    localparam int STAT_LIMP = 0;
    localparam logic LCH_RESET = 1'b1;
    localparam logic BIT0_RESET = 1'b0;
    localparam logic [2:0] OUT_RESET = 3'h0;
    localparam logic [2:0] MUX_DEFAULT = 3'h7;
    // ------------------------------------------------------------
    // Synchroniser vector positions and reset levels
    // ------------------------------------------------------------
    localparam int SY_SCLK = 0;
    localparam int SY_CSN = 1;
    localparam int SY_MOSI = 2;
    localparam int SY_PIN = 3;
    localparam int SY_LHI = 4;
    localparam logic [4:0] SYNC_RESET = 5'h02;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int T_WAKEUP_NS = 20000;
    localparam int T_CS_TD_NS = 1000;
    localparam int HALF_SCLK_NS = 128;
    localparam logic [11:0] WAKEUP_CYC =
        12'((T_WAKEUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] CS_TD_CYC =
        12'((T_CS_TD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] HALF_CYC = 12'(HALF_SCLK_NS / CLK_PERIOD_NS);
    localparam logic [11:0] GAP_CYC = 12'(2 * (HALF_SCLK_NS / CLK_PERIOD_NS));
    localparam logic [4:0] HOST_EDGES = 5'h10;
    // ------------------------------------------------------------
    // Host command port
    // ------------------------------------------------------------
    localparam logic [1:0] HOST_TX = 2'h0;
    localparam logic [1:0] HOST_STAT = 2'h1;
    localparam logic [1:0] HOST_RX = 2'h2;
    typedef enum logic [1:0] {
        H_IDLE = 2'h0,
        H_SHIFT = 2'h1,
        H_GAP = 2'h3
    } clrc_hstate_t;
endpackage : clrc_pkg

// *** pkg/clrc_spi_if.sv ***
// SPI link between host and controller.
// Assumes MISO is released when not driven; the line then reads high.
`timescale 1ns/1ps
`default_nettype none
interface clrc_spi_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    wire miso_line;
    // Pull-up when the controller lets go of the line
    assign miso_line = miso_oe ? miso : 1'b1;
    modport dev (input sclk, input cs_n, input mosi,
                 output miso, output miso_oe);
    modport host (output sclk, output cs_n, output mosi,
                  input miso_line);
endinterface : clrc_spi_if
`default_nettype wire

// *** hw/clrc_host.sv ***
// Host end: SPI master with a small command port for software.
// Assumes the controller samples on rising SCLK and shifts on falling.
`timescale 1ns/1ps
`default_nettype none
module clrc_host import clrc_pkg::*; (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // SPI link
    clrc_spi_if.host spi,
    // Command port
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata
);
    // ------------------------------------------------------------
    // MISO synchroniser
    // ------------------------------------------------------------
    logic m1_q;
    logic m2_q;
    logic m3_q;
    logic mf_q;
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            m1_q <= 1'b1;
            m2_q <= 1'b1;
            m3_q <= 1'b1;
            mf_q <= 1'b1;
        end else begin
            m1_q <= spi.miso_line;
            m2_q <= m1_q;
            m3_q <= m2_q;
            if (m2_q == m3_q) begin
                mf_q <= m3_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Frame engine
    // ------------------------------------------------------------
    clrc_hstate_t st_q;
    logic [11:0] cnt_q;
    logic [4:0] edges_q;
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    logic rst_cmd_q;
    logic sclk_q;
    logic cs_n_q;
    logic mosi_q;
    // R14: frame addressing the configuration reset command
    wire is_rst_cmd = i_wdata[F_WRITE] &&
                      (i_wdata[F_SEL_HI:F_SEL_LO] == SEL_CONFIG) &&
                      i_wdata[CFG_STB_RST];
    wire start = i_wr && (i_addr == HOST_TX) && (st_q == H_IDLE);
    wire tick = (cnt_q == 12'h000);
    // Frames are refused while busy; software polls the status word
    wire [7:0] rd_mux = (i_addr == HOST_STAT) ? {7'h00, st_q != H_IDLE} :
                        (i_addr == HOST_RX) ? rx_q : 8'h00;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            // R8: hold off after power-on for the wake-up delay
            st_q <= H_GAP;
            cnt_q <= WAKEUP_CYC;
            edges_q <= 5'h00;
            tx_q <= 8'h00;
            rx_q <= 8'h00;
            rst_cmd_q <= 1'b0;
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
            mosi_q <= 1'b0;
        end else begin
            case (st_q)
                H_IDLE: begin
                    if (start) begin
                        tx_q <= i_wdata;
                        mosi_q <= i_wdata[F_WRITE];
                        cs_n_q <= 1'b0;
                        cnt_q <= HALF_CYC - 12'h001;
                        edges_q <= 5'h00;
                        rst_cmd_q <= is_rst_cmd;
                        st_q <= H_SHIFT;
                    end
                end
                H_SHIFT: begin
                    if (!tick) begin
                        cnt_q <= cnt_q - 12'h001;
                    end else if (edges_q == HOST_EDGES) begin
                        cs_n_q <= 1'b1;
                        // R10: longer pause after a reset command
                        cnt_q <= rst_cmd_q ? CS_TD_CYC : GAP_CYC;
                        st_q <= H_GAP;
                    end else begin
                        cnt_q <= HALF_CYC - 12'h001;
                        edges_q <= edges_q + 5'h01;
                        if (!sclk_q) begin
                            sclk_q <= 1'b1;
                            rx_q <= {rx_q[6:0], mf_q};
                        end else begin
                            sclk_q <= 1'b0;
                            tx_q <= {tx_q[6:0], 1'b0};
                            mosi_q <= tx_q[6];
                        end
                    end
                end
                H_GAP: begin
                    if (tick) begin
                        st_q <= H_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 12'h001;
                    end
                end
                default: begin
                    st_q <= H_IDLE;
                end
            endcase
        end
    end

    // Read data stand for one cycle per cycle of i_rd, one cycle late
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= i_rd ? rd_mux : 8'h00;
        end
    end

    assign spi.sclk = sclk_q;
    assign spi.cs_n = cs_n_q;
    assign spi.mosi = mosi_q;
endmodule : clrc_host
`default_nettype wire

// *** bench/clrc_properties.sv ***
// Concurrent checks on the SPI link and the controller pins.
// Assumes one system clock; instantiated beside the link in the bench.
`timescale 1ns/1ps
`default_nettype none
module clrc_properties (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // SPI link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    // Controller pins
    input wire logic i_ch5_input_pin,
    input wire logic i_limp_home_input,
    input wire logic o_ch5_gate,
    input wire logic o_standby,
    input wire logic o_thermal_latch_clear,
    input wire logic o_limp_home_active
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_reset);
    // ------------------------------------------------
    // Helpers: clock rises per frame, first frame
    // ------------------------------------------------
    logic sclk_q;
    logic [3:0] rises_q;
    logic [3:0] rises_d;
    logic fresh_q;
    logic fresh_d;
    wire sclk_rise;
    assign sclk_rise = sclk && !sclk_q;
    assign rises_d = cs_n ? 4'h0 : rises_q + {3'h0, sclk_rise};
    assign fresh_d = fresh_q && !sclk_rise;
    always_ff @(posedge i_sys_clk) begin
        sclk_q <= sclk;
        rises_q <= i_reset ? 4'h0 : rises_d;
        fresh_q <= i_reset ? 1'b1 : fresh_d;
    end
    // Filter lag is five cycles, so eight leaves margin
    sequence s_limp_pin_low;
        (o_limp_home_active && !i_ch5_input_pin) [*8];
    endsequence
    sequence s_limp_pin_high;
        (o_limp_home_active && i_ch5_input_pin) [*8];
    endsequence
    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    // frame framing
    AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
        else $error("sclk high outside a frame");
    AST_MOSI_STABLE: assert property (sclk_rise |-> $stable(mosi))
        else $error("mosi moved at a sampling edge");
    AST_FRAME_RISES: assert property ($rose(cs_n) |-> rises_q == 4'h8)
        else $error("frame without eight clock rises");
    AST_MISO_RELEASE: assert property (cs_n [*8] |-> !miso_oe)
        else $error("miso driven while deselected");
    AST_TER_FIRST: assert property (sclk_rise && fresh_q |-> miso)
        else $error("first answer bit low after reset");
    AST_NO_STB_ON: assert property (
        o_ch5_gate && $past(o_ch5_gate) |-> !o_standby)
        else $error("stand-by while channel on");
    AST_THERM_PULSE: assert property (
        o_thermal_latch_clear |=> !o_thermal_latch_clear)
        else $error("thermal clear longer than one cycle");
    AST_THERM_ENTRY: assert property (
        o_thermal_latch_clear |-> ##[0:2] o_standby)
        else $error("thermal clear without stand-by");
    AST_LIMP_ENTER: assert property (
        i_limp_home_input [*8] |-> o_limp_home_active)
        else $error("limp-home not entered");
    AST_LIMP_PIN_OFF: assert property (s_limp_pin_low |-> !o_ch5_gate)
        else $error("channel on in limp-home with pin low");
    AST_LIMP_PIN_ON: assert property (s_limp_pin_high |-> o_ch5_gate)
        else $error("channel off in limp-home with pin high");
endmodule : clrc_properties
`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking bench: host and controller joined over one SPI link.
// Assumes clrc_pkg, the link interface and both ends are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    n_fail++; $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench import clrc_pkg::*;;
    logic clk, rst, wr, rd, pin, limp;
    logic [1:0] addr;
    logic [7:0] wdata, rdata, rx, ans;
    logic gate, stb, tclr, lha;
    logic [31:0] seed = 32'h7da9;
    int n_fail = 0;
    int samples_checked = 0;
    int n_tclr = 0;
    clrc_spi_if spi_link ();
    clrc_host u_clrc_host (.i_sys_clk(clk), .i_reset(rst), .spi(spi_link),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata));
    clrc_device u_clrc_device (.i_sys_clk(clk), .i_reset(rst),
        .spi(spi_link), .i_ch5_input_pin(pin), .i_limp_home_input(limp),
        .o_ch5_gate(gate), .o_standby(stb), .o_thermal_latch_clear(tclr),
        .o_limp_home_active(lha));
    clrc_properties u_clrc_properties (.i_sys_clk(clk), .i_reset(rst),
        .sclk(spi_link.sclk), .cs_n(spi_link.cs_n), .mosi(spi_link.mosi),
        .miso(spi_link.miso), .miso_oe(spi_link.miso_oe),
        .i_ch5_input_pin(pin), .i_limp_home_input(limp),
        .o_ch5_gate(gate), .o_standby(stb), .o_thermal_latch_clear(tclr),
        .o_limp_home_active(lha));
    // ------------------------------------------------
    // Expectations and stimulus helpers
    // ------------------------------------------------
    function automatic logic [7:0] cfg_ans(logic t, logic c, logic l,
        logic s, logic b);
        return {t, SEL_CONFIG, c, l, s, b};
    endfunction : cfg_ans
    function automatic logic [31:0] xs(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic cyc(input logic w, input logic [1:0] a,
        input logic [7:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 rx = rdata;
    endtask : cyc
    // Bounded poll; the host stays busy through wake-up and gaps
    task automatic idle;
        for (int k = 0; k < 3000; k++) begin
            cyc(1'b0, HOST_STAT, 8'h00);
            if (rx[0] === 1'b0) begin
                break;
            end
        end
        `CHK("host_idle", 1'b0, rx[0])
    endtask : idle
    task automatic frame(input logic [7:0] c);
        idle();
        cyc(1'b1, HOST_TX, c);
        idle();
        cyc(1'b0, HOST_RX, 8'h00);
        ans = rx;
    endtask : frame
    task automatic pins(input logic p, input logic l);
        @(posedge clk);
        pin <= p;
        limp <= l;
        repeat (12) @(posedge clk);
        #1;
    endtask : pins
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    // ------------------------------------------------
    // Clock, watchdog, scenarios
    // ------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        if (tclr === 1'b1) begin
            n_tclr++;
        end
    end
    initial begin
        repeat (80000) @(posedge clk);
        n_fail++;
        $display("BAD watchdog exp done got timeout");
        test_done();
    end
    initial begin
        {rst, wr, rd, pin, limp, addr, wdata} = {1'b1, 14'h0};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        frame(8'h60);
        `CHK("first_ans", 8'h80, ans)
        frame(8'h60);
        `CHK("cfg_rst", cfg_ans(1'b0, 1'b0, 1'b1, 1'b1, 1'b0), ans)
        `CHK("stb_rst", 1'b1, stb)
        cyc(1'b0, 2'h3, 8'h00);
        `CHK("unmapped", 8'h00, rx)
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            frame({4'he, seed[4], 2'b10, seed[0]});
            frame({5'h12, seed[3:1]});
            frame(8'h60);
            frame(8'h60);
            `CHK("cfg_rand", cfg_ans(1'b0, 1'b0, 1'b1, seed[3:1] == 3'h7,
                seed[0]), ans)
            `CHK("stb_rand", seed[3:1] == 3'h7, stb)
        end
        frame(8'h93);
        `CHK("wake", 1'b0, stb)
        n_tclr = 0;
        frame(8'h97);
        `CHK("tclr", 1, n_tclr)
        pins(1'b1, 1'b0);
        pins(1'b0, 1'b0);
        `CHK("latch_pin", 1'b1, gate)
        `CHK("no_stb", 1'b0, stb)
        frame(8'he7);
        repeat (130) @(posedge clk);
        `CHK("gate_kept", 1'b1, gate)
        frame(8'h60);
        `CHK("ter_cmd", 8'h80, ans)
        frame(8'h60);
        `CHK("cfg_cmd", cfg_ans(1'b0, 1'b1, 1'b1, 1'b0, 1'b0), ans)
        frame(8'he0);
        pins(1'b0, 1'b0);
        `CHK("unlatch", 1'b0, gate)
        `CHK("stb_back", 1'b1, stb)
        pins(1'b1, 1'b0);
        `CHK("transp_on", 1'b1, gate)
        pins(1'b0, 1'b0);
        `CHK("transp_off", 1'b0, gate)
        frame(8'he4);
        frame(8'h81);
        frame(8'h80);
        pins(1'b0, 1'b0);
        `CHK("latch_req", 1'b1, gate)
        frame(8'he0);
        pins(1'b0, 1'b1);
        `CHK("limp_act", 1'b1, lha)
        `CHK("limp_gate", 1'b0, gate)
        frame(8'h20);
        `CHK("limp_ter", 1'b1, ans[7])
        frame(8'he5);
        `CHK("limp_stat", 8'h21, ans)
        frame(8'h60);
        frame(8'h60);
        `CHK("limp_cfg", cfg_ans(1'b0, 1'b0, 1'b1, 1'b0, 1'b0), ans)
        pins(1'b1, 1'b1);
        `CHK("limp_on", 1'b1, gate)
        pins(1'b0, 1'b1);
        `CHK("limp_off", 1'b0, gate)
        pins(1'b0, 1'b0);
        `CHK("limp_exit", 1'b1, stb)
        test_done();
    end
endmodule : testbench
`default_nettype wire
